// [stp_pkg.sv]
// stp_pkg: shared constants and types for the stepper sequencer pair
// assumes a single 50 MHz clock on both ends
package stp_pkg;

  // ------------------------------------------------------------------
  // clock and interval timing
  // ------------------------------------------------------------------
  localparam int CLK_NS      = 20;
  localparam int BLANK_NS    = 750;
  localparam int BLANK_CYC   = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF_US      = 400;
  localparam int OFF_CYC     = (OFF_US * 1000) / CLK_NS;
  localparam int GF_US       = 6;
  localparam int GF_CYC      = (GF_US * 1000) / CLK_NS;
  localparam int OC_US       = 5;
  localparam int OC_CYC      = (OC_US * 1000) / CLK_NS;
  localparam int STEP_PW_US  = 10;
  localparam int STEP_PW_CYC = (STEP_PW_US * 1000 + CLK_NS - 1) / CLK_NS;

  // ------------------------------------------------------------------
  // counter widths and position layout
  // ------------------------------------------------------------------
  localparam int CNT_W   = 15;
  localparam int BLANK_W = 6;
  localparam int OC_W    = 8;
  localparam int PW_W    = 9;
  localparam int POS_W   = 6;
  // index 0 of the 64-step circle is the minus 45 degree point
  localparam int          DEF_ANGLE_DEG = -45;
  localparam logic [5:0]  DEF_POS       = 6'h00;

  // excitation select bits: [0] st1, [1] st2, [2] st3
  localparam int MODE_ST1 = 0;
  localparam int MODE_ST2 = 1;
  localparam int MODE_ST3 = 2;
  localparam logic [5:0] INC_2PH  = 6'h10;
  localparam logic [5:0] INC_HALF = 6'h08;
  localparam logic [5:0] INC_W12  = 6'h04;
  localparam logic [5:0] INC_2W12 = 6'h02;
  localparam logic [5:0] INC_4W12 = 6'h01;

  typedef enum logic [2:0] {
    STP_HOLD = 3'h0,
    STP_OFF  = 3'h1,
    STP_GF   = 3'h2,
    STP_RUN  = 3'h3,
    STP_STOP = 3'h4
  } stp_state_e;

  typedef enum logic [1:0] {
    STH_IDLE = 2'h0,
    STH_HIGH = 2'h1,
    STH_LOW  = 2'h2
  } stp_hphase_e;

  // step size on the 64-step circle for the selected excitation
  function automatic logic [5:0] stp_step_inc(input logic [2:0] mode);
    logic [5:0] inc;
    inc = INC_2PH;
    if (mode[MODE_ST3])
      inc = mode[MODE_ST1] ? INC_4W12 : INC_2W12;
    else if (mode[MODE_ST1] && mode[MODE_ST2])
      inc = INC_W12;
    else if (mode[MODE_ST1] || mode[MODE_ST2])
      inc = INC_HALF;
    return inc;
  endfunction : stp_step_inc

endpackage : stp_pkg

// [stp_if.sv]
// stp_if: control pins between the host controller and the driver logic
// assumes both ends share clk_i; all pins are plain levels
`timescale 1ns/1ns
`default_nettype none
interface stp_if;
  logic       step_rise_input;
  logic       step_both_edge_input;
  logic       dir;
  logic [2:0] mode;
  logic       enable;
  logic       reset_n;
  logic       low_power_hold_n;
  logic       decay_ratio_sel_a;
  logic       decay_ratio_sel_a_oe;
  logic       decay_ratio_sel_b;
  logic       decay_ratio_sel_b_oe;
  logic       pwm_off_time_sel;
  logic       pwm_off_time_sel_oe;
  logic       test_sel;

  modport host (
    output step_rise_input, step_both_edge_input, dir, mode, enable, reset_n,
           low_power_hold_n, decay_ratio_sel_a, decay_ratio_sel_a_oe,
           decay_ratio_sel_b, decay_ratio_sel_b_oe, pwm_off_time_sel,
           pwm_off_time_sel_oe, test_sel
  );
  modport dev (
    input  step_rise_input, step_both_edge_input, dir, mode, enable, reset_n,
           low_power_hold_n, decay_ratio_sel_a, decay_ratio_sel_a_oe,
           decay_ratio_sel_b, decay_ratio_sel_b_oe, pwm_off_time_sel,
           pwm_off_time_sel_oe, test_sel
  );
endinterface : stp_if
`default_nettype wire

// [stp_host.sv]
// stp_host: controller end, turns user requests into step and control pins
// assumes the pump ready indication comes from board-level monitoring
`timescale 1ns/1ns
`default_nettype none
module stp_host
  import stp_pkg::*;
#(
  parameter int STEP_PW = STEP_PW_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // user requests
  input  wire logic       step_req_i,
  input  wire logic       dir_i,
  input  wire logic [2:0] mode_i,
  input  wire logic       edge_sel_i,
  input  wire logic       run_req_i,
  input  wire logic       enable_req_i,
  input  wire logic       reset_req_i,
  input  wire logic       pump_ready_i,
  input  wire logic [1:0] decay_i,
  input  wire logic [1:0] decay_open_i,
  input  wire logic       pwm_sel_i,
  input  wire logic       test_i,
  // user status
  output logic            busy_o,
  output logic            enable_o,
  // pins
  stp_if.host             pins
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    stp_hphase_e     phase;
    logic [PW_W-1:0] cnt;
    logic            rise;
    logic            both;
    logic            dir;
    logic [2:0]      mode;
    logic            enable;
    logic            reset_n;
    logic            hold_n;
    logic [1:0]      decay;
    logic [1:0]      decay_oe;
    logic            pwm_sel;
    logic            test;
    logic            busy;
  } stp_host_s;

  stp_host_s r_reg;
  stp_host_s r_next;

  // pin sequencing, pulse widths kept by counter
  always_comb
  begin
    r_next          = r_reg;
    r_next.hold_n   = run_req_i;
    r_next.reset_n  = ~reset_req_i;
    // enable waits for the pump rail and stays low while standby is requested
    r_next.enable   = enable_req_i & pump_ready_i & run_req_i;
    r_next.decay    = decay_i;
    r_next.decay_oe = ~decay_open_i;
    r_next.pwm_sel  = pwm_sel_i;
    r_next.test     = test_i;
    case (r_reg.phase)
      STH_IDLE:
      begin
        // direction and mode move only between steps
        r_next.dir  = dir_i;
        r_next.mode = mode_i;
        r_next.cnt  = '0;
        if (step_req_i)
        begin
          if (edge_sel_i)
          begin
            r_next.both  = ~r_reg.both;
            r_next.phase = STH_LOW;
          end
          else
          begin
            r_next.rise  = 1'b1;
            r_next.phase = STH_HIGH;
          end
        end
      end
      STH_HIGH:
      begin
        r_next.cnt = r_reg.cnt + 1'b1;
        if (r_reg.cnt == PW_W'(STEP_PW - 1))
        begin
          r_next.rise  = 1'b0;
          r_next.cnt   = '0;
          r_next.phase = STH_LOW;
        end
      end
      STH_LOW:
      begin
        r_next.cnt = r_reg.cnt + 1'b1;
        if (r_reg.cnt == PW_W'(STEP_PW - 1))
          r_next.phase = STH_IDLE;
      end
      default:
        r_next.phase = STH_IDLE;
    endcase
    // busy kept as a flop so the status output has no decode behind it
    r_next.busy = (r_next.phase != STH_IDLE);
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_reg         <= '0;
      r_reg.phase   <= STH_IDLE;
      r_reg.decay_oe <= 2'h3;
    end
    else
      r_reg <= r_next;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign busy_o                    = r_reg.busy;
  assign enable_o                  = r_reg.enable;
  assign pins.step_rise_input      = r_reg.rise;
  assign pins.step_both_edge_input = r_reg.both;
  assign pins.dir                  = r_reg.dir;
  assign pins.mode                 = r_reg.mode;
  assign pins.enable               = r_reg.enable;
  assign pins.reset_n              = r_reg.reset_n;
  assign pins.low_power_hold_n     = r_reg.hold_n;
  assign pins.decay_ratio_sel_a    = r_reg.decay[0];
  assign pins.decay_ratio_sel_a_oe = r_reg.decay_oe[0];
  assign pins.decay_ratio_sel_b    = r_reg.decay[1];
  assign pins.decay_ratio_sel_b_oe = r_reg.decay_oe[1];
  assign pins.pwm_off_time_sel     = r_reg.pwm_sel;
  assign pins.pwm_off_time_sel_oe  = 1'b1;   // never left open
  assign pins.test_sel             = r_reg.test;

endmodule : stp_host
`default_nettype wire

// [stp_dev.sv]
// stp_dev: driver-side step-state and protection sequencing
// assumes pins and analog comparator flags are synchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module stp_dev
  import stp_pkg::*;
#(
  parameter int OFF_CNT   = OFF_CYC,
  parameter int GF_CNT    = GF_CYC,
  parameter int OC_CNT    = OC_CYC,
  parameter int BLANK_CNT = BLANK_CYC
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // pins from the host
  stp_if.dev                    pins,
  // analog side flags
  input  wire logic             supply_low_lockout_i,
  input  wire logic             pwm_on_i,
  input  wire logic             sense_cmp_i,
  input  wire logic             over_limit_i,
  input  wire logic             ground_fault_i,
  // drive and status
  output logic                  drive_on_o,
  output logic                  high_side_all_o,
  output logic                  pump_run_o,
  output logic [POS_W-1:0]      position_o,
  output logic                  chop_off_o,
  output logic                  overcurrent_latch_o,
  output logic                  ground_fault_stop_o,
  output logic [2:0]            state_o,
  output logic [1:0]            decay_o,
  output logic                  pwm_off_time_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    stp_state_e         state;
    logic [CNT_W-1:0]   cnt;
    logic [POS_W-1:0]   pos;
    logic [1:0]         step_prev;
    logic               pwm_prev;
    logic [BLANK_W-1:0] blank;
    logic [OC_W-1:0]    oc_cnt;
    logic               oc_latch;
    logic               gf_stop;
    logic               drive;
    logic               hs_all;
    logic               pump;
    logic               chop_off;
    logic [1:0]         decay;
    logic               pwm_sel;
  } stp_dev_s;

  stp_dev_s r_reg;
  stp_dev_s r_next;

  logic       step_edge;
  logic       pwm_rise;
  logic       held;
  logic [5:0] inc;

  // ------------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------------
  always_comb
  begin
    r_next    = r_reg;
    // rise-only pin or either edge of the both-edge pin
    step_edge = (pins.step_rise_input & ~r_reg.step_prev[0])
              | (pins.step_both_edge_input ^ r_reg.step_prev[1]);
    pwm_rise  = pwm_on_i & ~r_reg.pwm_prev;
    // only lockout and standby hold; a supply move in range does not
    held      = ~pins.low_power_hold_n | supply_low_lockout_i;
    inc       = stp_step_inc(pins.mode);
    r_next.step_prev = {pins.step_both_edge_input, pins.step_rise_input};
    r_next.pwm_prev  = pwm_on_i;
    // an undriven decay select is taken as low
    r_next.decay   = {pins.decay_ratio_sel_b & pins.decay_ratio_sel_b_oe,
                      pins.decay_ratio_sel_a & pins.decay_ratio_sel_a_oe};
    r_next.pwm_sel = pins.pwm_off_time_sel;

    case (r_reg.state)
      STP_HOLD:
      begin
        r_next.cnt = '0;
        if (!held)
        begin
          r_next.state = STP_OFF;
          r_next.pos   = DEF_POS;
        end
      end
      STP_OFF:
      begin
        r_next.cnt = r_reg.cnt + 1'b1;
        if (r_reg.cnt == CNT_W'(OFF_CNT - 1))
        begin
          r_next.cnt = '0;
          if (pins.reset_n)
            r_next.state = STP_GF;
          else
            r_next.state = STP_RUN;
        end
      end
      STP_GF:
      begin
        r_next.cnt = r_reg.cnt + 1'b1;
        if (ground_fault_i)
        begin
          r_next.gf_stop = 1'b1;
          r_next.state   = STP_STOP;
        end
        else if (r_reg.cnt == CNT_W'(GF_CNT - 1) || !pins.reset_n)
          r_next.state = STP_RUN;
      end
      STP_RUN:
        r_next.cnt = '0;
      STP_STOP:
        r_next.cnt = '0;
      default:
        r_next.state = STP_HOLD;
    endcase

    // position keeps counting while outputs are merely disabled
    if (step_edge && r_reg.state != STP_HOLD)
    begin
      if (pins.dir)
        r_next.pos = r_next.pos - inc;
      else
        r_next.pos = r_next.pos + inc;
    end

    // over-limit must persist for the full qualification time
    if (r_reg.drive && over_limit_i)
    begin
      r_next.oc_cnt = r_reg.oc_cnt + 1'b1;
      if (r_reg.oc_cnt == OC_W'(OC_CNT - 1))
        r_next.oc_latch = 1'b1;
    end
    else
      r_next.oc_cnt = '0;

    // reset pin: default position, fault cleared, sequencer state left running
    if (!pins.reset_n)
    begin
      r_next.pos      = DEF_POS;
      r_next.oc_latch = 1'b0;
      r_next.oc_cnt   = '0;
    end

    // standby or lockout overrides everything and halts the pump
    if (held)
    begin
      r_next.state    = STP_HOLD;
      r_next.cnt      = '0;
      r_next.oc_latch = 1'b0;
      r_next.oc_cnt   = '0;
      r_next.gf_stop  = 1'b0;
    end
    r_next.pump   = (r_next.state != STP_HOLD);
    r_next.hs_all = (r_next.state == STP_GF);
    r_next.drive  = (r_next.state == STP_RUN) & pins.enable
                  & pins.reset_n & ~r_next.oc_latch;

    // blanking restarts on every turn-on edge
    if (pwm_rise)
      r_next.blank = BLANK_W'(BLANK_CNT);
    else if (r_reg.blank != '0)
      r_next.blank = r_reg.blank - 1'b1;
    r_next.chop_off = r_reg.drive & sense_cmp_i & ~pwm_rise
                    & (r_reg.blank == '0);
  end

  // state register; power-up starts in hold so the off interval runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_reg       <= '0;
      r_reg.state <= STP_HOLD;
      r_reg.pos   <= DEF_POS;
    end
    else
      r_reg <= r_next;
  end

  // ------------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign drive_on_o          = r_reg.drive;
  assign high_side_all_o     = r_reg.hs_all;
  assign pump_run_o          = r_reg.pump;
  assign position_o          = r_reg.pos;
  assign chop_off_o          = r_reg.chop_off;
  assign overcurrent_latch_o = r_reg.oc_latch;
  assign ground_fault_stop_o = r_reg.gf_stop;
  assign state_o             = r_reg.state;
  assign decay_o             = r_reg.decay;
  assign pwm_off_time_o      = r_reg.pwm_sel;

endmodule : stp_dev
`default_nettype wire

// [stp_dev_end.sv]
// stp_dev_end: spare source unit for the driver end, holds no logic
// assumes the driver logic itself lives in stp_dev
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [stp_asserts.sv]
// stp_asserts: timing checks on the pins and sequencer outputs
// assumes one clock domain and the shortened counts used in simulation
`timescale 1ns/1ns
`default_nettype none
module stp_asserts
  import stp_pkg::*;
#(
  parameter int OFF_CNT = 20,
  parameter int OC_CNT  = 6
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control pins
  input  wire logic       enable,
  input  wire logic       reset_n,
  input  wire logic       low_power_hold_n,
  // analog flags
  input  wire logic       supply_low_lockout_i,
  input  wire logic       pwm_on_i,
  input  wire logic       over_limit_i,
  input  wire logic       ground_fault_i,
  // sequencer outputs
  input  wire logic       drive_on_o,
  input  wire logic       high_side_all_o,
  input  wire logic       pump_run_o,
  input  wire logic [5:0] position_o,
  input  wire logic       chop_off_o,
  input  wire logic       overcurrent_latch_o,
  input  wire logic [2:0] state_o
);
  localparam int OFF_M1 = OFF_CNT - 1;
  logic       clr_cond;
  logic [7:0] oc_run_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // any source that clears the latched fault
  assign clr_cond = !reset_n || !low_power_hold_n || supply_low_lockout_i;

  // run length of over-limit while driving; a counter avoids a long repetition
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !(drive_on_o && over_limit_i))
      oc_run_reg <= 8'h00;
    else
      oc_run_reg <= oc_run_reg + 8'h01;
  end

  // -------------------------------------------------------------------
  // release sequence
  // -------------------------------------------------------------------
  sequence s_off_entry;
    $rose(state_o == 3'h1);
  endsequence
  sequence s_off_span;
    ##OFF_M1 (state_o == 3'h1) ##1 (state_o != 3'h1);
  endsequence

  a_off_span:
    assert property (s_off_entry |-> s_off_span) else $error("off interval length wrong");
  a_off_quiet:
    assert property (state_o == 3'h1 |-> !drive_on_o && !high_side_all_o)
      else $error("drive during off interval");
  a_release_pos:
    assert property (s_off_entry |-> position_o == 6'h00 && pump_run_o)
      else $error("release did not reset position or start pump");
  a_hold_pump:
    assert property ((!low_power_hold_n || supply_low_lockout_i) |=> state_o == 3'h0 && !pump_run_o)
      else $error("pump or state not halted");
  a_gf_entry:
    assert property ($past(state_o) == 3'h1 && state_o == 3'h2 |-> $past(reset_n) && high_side_all_o)
      else $error("ground check entry wrong");
  a_no_gf_check:
    assert property ($past(state_o) == 3'h1 && state_o == 3'h3 |-> !$past(reset_n))
      else $error("ground check skipped with reset high");
  a_gf_stop:
    assert property (state_o == 3'h2 && ground_fault_i && !clr_cond |=> state_o == 3'h4 && !drive_on_o)
      else $error("ground fault did not stop drive");
  a_enable_off:
    assert property (!enable || !reset_n |=> !drive_on_o) else $error("drive with enable or reset low");
  a_reset_pos:
    assert property (!reset_n |=> position_o == 6'h00) else $error("position kept in reset");
  a_oc_latch:
    assert property (oc_run_reg == OC_CNT && !$past(clr_cond) |-> ##[0:1] overcurrent_latch_o)
      else $error("no fault latch");
  a_oc_off:
    assert property (overcurrent_latch_o |=> !drive_on_o) else $error("drive with fault latched");
  a_oc_clear:
    assert property ($fell(overcurrent_latch_o) |-> $past(clr_cond)) else $error("fault cleared alone");
  a_blank_hold:
    assert property ($rose(pwm_on_i) |-> ##1 (!chop_off_o) [*5]) else $error("chop inside blanking");
endmodule : stp_asserts
`default_nettype wire

// [stepper_state_and_protection_sequencer_tb_top.sv]
// testbench top: host and device ends joined by stp_if, random steps plus corners
// assumes shortened interval counts; expectations come from bench functions
`timescale 1ns/1ns
`default_nettype none
module stepper_state_and_protection_sequencer_tb_top;
  import stp_pkg::*;
  localparam int OFF_N = 20;
  localparam int GF_N  = 8;
  localparam int OC_N  = 6;
  logic       clk_i, rst_i, step_req_i, dir_i, edge_sel_i, run_req_i, enable_req_i;
  logic       reset_req_i, pump_ready_i, pwm_sel_i, test_i, busy_o, enable_o;
  logic [2:0] mode_i, state_o;
  logic [1:0] decay_i, decay_open_i, decay_o;
  logic       lockout, pwm_on, sense_cmp, over_limit, gnd_fault, pwm_off_time_o;
  logic       drive_on, hs_all, pump_run, chop_off, oc_latch, gf_stop;
  logic [5:0] position_o, exp_pos;
  int         err_count, checks, seed, n, i;
  logic [31:0] r;

  stp_if stp_if_i ();
  stp_host #(.STEP_PW(3)) stp_host_i (.clk_i(clk_i), .rst_i(rst_i), .step_req_i(step_req_i),
    .dir_i(dir_i), .mode_i(mode_i), .edge_sel_i(edge_sel_i), .run_req_i(run_req_i),
    .enable_req_i(enable_req_i), .reset_req_i(reset_req_i), .pump_ready_i(pump_ready_i),
    .decay_i(decay_i), .decay_open_i(decay_open_i), .pwm_sel_i(pwm_sel_i), .test_i(test_i),
    .busy_o(busy_o), .enable_o(enable_o), .pins(stp_if_i));
  stp_dev #(.OFF_CNT(OFF_N), .GF_CNT(GF_N), .OC_CNT(OC_N), .BLANK_CNT(4)) stp_dev_i (
    .clk_i(clk_i), .rst_i(rst_i), .pins(stp_if_i), .supply_low_lockout_i(lockout),
    .pwm_on_i(pwm_on), .sense_cmp_i(sense_cmp), .over_limit_i(over_limit),
    .ground_fault_i(gnd_fault), .drive_on_o(drive_on), .high_side_all_o(hs_all),
    .pump_run_o(pump_run), .position_o(position_o), .chop_off_o(chop_off),
    .overcurrent_latch_o(oc_latch), .ground_fault_stop_o(gf_stop), .state_o(state_o),
    .decay_o(decay_o), .pwm_off_time_o(pwm_off_time_o));
  stp_asserts #(.OFF_CNT(OFF_N), .OC_CNT(OC_N)) stp_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
    .enable(stp_if_i.enable), .reset_n(stp_if_i.reset_n),
    .low_power_hold_n(stp_if_i.low_power_hold_n), .supply_low_lockout_i(lockout),
    .pwm_on_i(pwm_on), .over_limit_i(over_limit), .ground_fault_i(gnd_fault),
    .drive_on_o(drive_on), .high_side_all_o(hs_all), .pump_run_o(pump_run),
    .position_o(position_o), .chop_off_o(chop_off), .overcurrent_latch_o(oc_latch),
    .state_o(state_o));

  // 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // step size expected for a mode, worked out from the excitation table
  function automatic logic [5:0] exp_inc(input logic [2:0] m);
    if (m[2])
      return m[0] ? 6'h01 : 6'h02;
    if (m[0] && m[1])
      return 6'h04;
    return (m[0] || m[1]) ? 6'h08 : 6'h10;
  endfunction : exp_inc

  task automatic chk_val(input string what, input logic [5:0] exp, input logic [5:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0b seen %0b", what, exp, got);
    end
  endtask : chk_bit

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick

  // bounded wait for a sequencer state, n returns the edges waited
  task automatic wait_st(input logic [2:0] s);
    n = 0;
    while (state_o !== s && n < 400)
    begin
      tick(1);
      n++;
    end
    chk_val("state", {3'h0, s}, {3'h0, state_o});
  endtask : wait_st

  // one host step; counted says whether the device should move
  task automatic do_step(input logic d, input logic [2:0] m, input logic counted);
    @(posedge clk_i);
    r = $random(seed);
    dir_i      <= d;
    mode_i     <= m;
    edge_sel_i <= r[0];
    pwm_sel_i  <= r[1];
    @(posedge clk_i);
    step_req_i <= 1'b1;
    @(posedge clk_i);
    step_req_i <= 1'b0;
    tick(1);
    for (int k = 0; k < 30 && busy_o !== 1'b0; k++)
      tick(1);
    tick(2);
    if (counted)
      exp_pos = d ? exp_pos - exp_inc(m) : exp_pos + exp_inc(m);
    chk_val("position", exp_pos, position_o);
    chk_bit("off time", pwm_sel_i, pwm_off_time_o);
  endtask : do_step

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // watchdog: whole sequence needs well under 3000 cycles, allow 10000
  initial
  begin
    #200000;
    err_count++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    seed = 65012;
    err_count = 0;
    checks = 0;
    {step_req_i, dir_i, edge_sel_i, run_req_i, enable_req_i, reset_req_i} = 6'h00;
    {pump_ready_i, pwm_sel_i, test_i, lockout, pwm_on, sense_cmp, over_limit, gnd_fault} = 8'h00;
    mode_i = 3'h0;
    r = $random(seed);
    decay_i = r[1:0];
    decay_open_i = r[3:2];
    exp_pos = 6'h00;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // release from standby with enable held off until the pump is up
    @(posedge clk_i);
    run_req_i    <= 1'b1;
    enable_req_i <= 1'b1;
    wait_st(3'h2);
    wait_st(3'h3);
    chk_val("check window", GF_N[5:0], n[5:0]);
    chk_val("position", 6'h00, position_o);
    chk_val("decay", {4'h0, decay_i & ~decay_open_i}, {4'h0, decay_o});
    chk_bit("enable pin", 1'b0, enable_o);
    chk_bit("drive", 1'b0, drive_on);
    pump_ready_i <= 1'b1;
    tick(4);
    chk_bit("enable pin", 1'b1, enable_o);
    chk_bit("drive", 1'b1, drive_on);
    $display("test 1 done");
    // random steps in all modes and both directions, wrap included
    for (i = 0; i < 24; i++)
    begin
      r = $random(seed);
      do_step(r[4], (i < 8) ? i[2:0] : r[2:0], 1'b1);
    end
    $display("test 2 done");
    // steps counted while outputs are off, then resume
    @(posedge clk_i);
    enable_req_i <= 1'b0;
    tick(3);
    chk_bit("drive", 1'b0, drive_on);
    for (i = 0; i < 3; i++)
      do_step(i[0], 3'h1, 1'b1);
    enable_req_i <= 1'b1;
    tick(3);
    chk_val("position", exp_pos, position_o);
    chk_bit("drive", 1'b1, drive_on);
    $display("test 3 done");
    // blanking, short and long over-limit, clear by reset, restart at default
    pwm_on    <= 1'b1;
    sense_cmp <= 1'b1;
    tick(5);
    chk_bit("chop", 1'b0, chop_off);
    tick(1);
    chk_bit("chop", 1'b1, chop_off);
    pwm_on     <= 1'b0;
    over_limit <= 1'b1;
    tick(OC_N - 1);
    over_limit <= 1'b0;
    tick(2);
    chk_bit("fault", 1'b0, oc_latch);
    over_limit <= 1'b1;
    tick(OC_N + 4);
    over_limit <= 1'b0;
    tick(4);
    chk_bit("fault", 1'b1, oc_latch);
    chk_bit("drive", 1'b0, drive_on);
    reset_req_i <= 1'b1;
    tick(3);
    chk_bit("fault", 1'b0, oc_latch);
    exp_pos = 6'h00;
    do_step(1'b0, 3'h4, 1'b0);
    reset_req_i <= 1'b0;
    do_step(1'b1, 3'h4, 1'b1);
    $display("test 4 done");
    // standby with reset low: no check window after the off interval
    run_req_i   <= 1'b0;
    reset_req_i <= 1'b1;
    tick(3);
    chk_val("state", 6'h00, {3'h0, state_o});
    chk_bit("pump", 1'b0, pump_run);
    run_req_i <= 1'b1;
    wait_st(3'h1);
    wait_st(3'h3);
    chk_val("off length", OFF_N[5:0], n[5:0]);
    reset_req_i <= 1'b0;
    $display("test 5 done");
    // lockout release with a ground fault in the check window
    lockout <= 1'b1;
    tick(3);
    lockout <= 1'b0;
    wait_st(3'h2);
    chk_bit("high sides", 1'b1, hs_all);
    gnd_fault <= 1'b1;
    wait_st(3'h4);
    chk_bit("ground stop", 1'b1, gf_stop);
    gnd_fault <= 1'b0;
    lockout   <= 1'b1;
    tick(2);
    lockout <= 1'b0;
    wait_st(3'h3);
    chk_bit("ground stop", 1'b0, gf_stop);
    $display("test 6 done");
    print_verdict();
  end
endmodule : stepper_state_and_protection_sequencer_tb_top
`default_nettype wire
